/* File: logic/usie_pkg.sv */
package usie_pkg;

   // ***************************************************************
   // Enable register field positions
   // ***************************************************************
   localparam int unsigned DEFAULT_EN_POS     = 7;
   localparam int unsigned ADDR_EN_POS        = 6;
   localparam int unsigned CONFIG_EN_POS      = 5;
   localparam int unsigned SUSPEND_EN_POS     = 4;
   localparam int unsigned CWR_STATUS_EN_POS  = 3;
   localparam int unsigned CRD_STATUS_EN_POS  = 2;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0] ENABLE_RST = 8'h00;

   // ***************************************************************
   // Device states and control stages
   // ***************************************************************
   typedef enum logic [2:0]
   {
      DEV_POWERED    = 3'h0,
      DEV_DEFAULT    = 3'h1,
      DEV_ADDRESS    = 3'h2,
      DEV_CONFIGURED = 3'h3,
      DEV_SUSPENDED  = 3'h4
   } usie_dev_state_e;

   typedef enum logic [2:0]
   {
      STG_IDLE       = 3'h0,
      STG_SETUP      = 3'h1,
      STG_RD_DATA    = 3'h2,
      STG_RD_STATUS  = 3'h3,
      STG_WR_DATA    = 3'h4,
      STG_WR_STATUS  = 3'h5,
      STG_ND_STATUS  = 3'h6
   } usie_ctrl_stage_e;

   // Current state and stage travel together
   typedef struct packed
   {
      usie_dev_state_e  dev_state;
      usie_ctrl_stage_e ctrl_stage;
   } usie_status_s;

   localparam usie_status_s STATUS_RST = '{dev_state: DEV_POWERED, ctrl_stage: STG_IDLE};

endpackage : usie_pkg

/* File: logic/usie_irq_enables.sv */
`timescale 1ns/1ps

module usie_irq_enables
(
   // Clock, reset and clock enable
   input  wire logic                 MCLK,
   input  wire logic                 RST_B,
   input  wire logic                 CE,
   // Enable register, written by the CPU side
   input  wire logic [7:0]           NOTIFY_ENABLE,
   // Current status from the USB core, same clock
   input  wire usie_pkg::usie_status_s CORE_STATUS,
   // Interrupt pulses
   output logic                      DEVICE_STATE_IRQ,
   output logic                      CONTROL_STAGE_IRQ,
   // Tracked status and enable readback
   output usie_pkg::usie_status_s    STATUS_OUT,
   output logic [7:0]                ENABLE_OUT
);

   // ***************************************************************
   // Reset release
   // ***************************************************************
   logic                   rst_meta_reg;
   logic                   rst_sync_reg;
   logic                   rst_n;

   // Release through two flops so every flop leaves reset on one edge
   // Assertion still acts at once, with no clock running
   // Only the second flop is read, never the first
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   assign rst_n = rst_sync_reg;

   // ***************************************************************
   // Enable decode
   // ***************************************************************
   logic                   default_state_notify_en;
   logic                   addr_state_notify_en;
   logic                   config_state_notify_en;
   logic                   suspend_notify_en;
   logic                   ctrl_write_status_notify_en;
   logic                   ctrl_read_status_notify_en;
   logic [7:0]             enable_reg;

   // Decoded from the stored copy, never from the raw input
   // Bits 1 and 0 are stored and read back but gate nothing
   assign default_state_notify_en     = enable_reg[usie_pkg::DEFAULT_EN_POS];
   assign addr_state_notify_en        = enable_reg[usie_pkg::ADDR_EN_POS];
   assign config_state_notify_en      = enable_reg[usie_pkg::CONFIG_EN_POS];
   assign suspend_notify_en           = enable_reg[usie_pkg::SUSPEND_EN_POS];
   assign ctrl_write_status_notify_en = enable_reg[usie_pkg::CWR_STATUS_EN_POS];
   assign ctrl_read_status_notify_en  = enable_reg[usie_pkg::CRD_STATUS_EN_POS];

   // ***************************************************************
   // Decode helpers
   // ***************************************************************

   // Small pure helpers, so the decode reads as a table
   // True when a 3-bit code differs from its stored copy
   // Shared by the state and stage paths so both detect entry alike
   function automatic logic code_changed
   (
      input logic [2:0] now_code,
      input logic [2:0] old_code
   );
      return now_code != old_code;
   endfunction : code_changed

   // Enable that gates entry into one device state
   // Powered has no enable of its own, so entering it never interrupts
   // Leaving suspend counts as entry to the state returned to
   function automatic logic dev_entry_enabled
   (
      input usie_pkg::usie_dev_state_e state,
      input logic                      dflt_en,
      input logic                      addr_en,
      input logic                      cfg_en,
      input logic                      suspend_notify_en_en
   );
      logic hit;
      hit = 1'b0;
      case (state)
         usie_pkg::DEV_DEFAULT    : hit = dflt_en;
         usie_pkg::DEV_ADDRESS    : hit = addr_en;
         usie_pkg::DEV_CONFIGURED : hit = cfg_en;
         usie_pkg::DEV_SUSPENDED  : hit = suspend_notify_en_en;
         default                  : hit = 1'b0;
      endcase
      return hit;
   endfunction : dev_entry_enabled

   // Enable that gates entry into one control stage
   // Setup, data and no-data status stages carry no enable at all
   // Leaving a status stage for idle never interrupts
   function automatic logic stage_entry_enabled
   (
      input usie_pkg::usie_ctrl_stage_e stage,
      input logic                       wr_en,
      input logic                       rd_en
   );
      logic hit;
      hit = 1'b0;
      case (stage)
         usie_pkg::STG_WR_STATUS : hit = wr_en;
         usie_pkg::STG_RD_STATUS : hit = rd_en;
         default                 : hit = 1'b0;
      endcase
      return hit;
   endfunction : stage_entry_enabled

   // ***************************************************************
   // Transition detect
   // ***************************************************************
   usie_pkg::usie_status_s status_reg;
   logic                   dev_irq_next;
   logic                   ctl_irq_next;
   logic                   dev_changed;
   logic                   stg_changed;

   // Compare against last cycle so a held state raises one pulse only
   assign dev_changed = code_changed(CORE_STATUS.dev_state, status_reg.dev_state);
   assign stg_changed = code_changed(CORE_STATUS.ctrl_stage, status_reg.ctrl_stage);

   // Gate by the enables held before this edge; a fresh write acts a cycle later
   assign dev_irq_next = dev_changed &&
                         dev_entry_enabled(CORE_STATUS.dev_state,
                                           default_state_notify_en,
                                           addr_state_notify_en,
                                           config_state_notify_en,
                                           suspend_notify_en);

   // Write and read status entries share one interrupt line
   // Only one stage is entered per cycle, so the two never pulse together
   assign ctl_irq_next = stg_changed &&
                         stage_entry_enabled(CORE_STATUS.ctrl_stage,
                                             ctrl_write_status_notify_en,
                                             ctrl_read_status_notify_en);

   // ***************************************************************
   // State registers
   // ***************************************************************
   logic                   dev_irq_reg;
   logic                   ctl_irq_reg;
   // Next values of the loaded registers
   logic [7:0]             enable_next;
   usie_pkg::usie_status_s status_next;

   // Next values are plain copies; CE alone decides whether they load
   assign enable_next = NOTIFY_ENABLE;
   assign status_next = CORE_STATUS;

   // Enable capture; takes effect on transitions from the next edge on
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_reg <= usie_pkg::ENABLE_RST;
      end
      else if (CE)
      begin
         enable_reg <= enable_next;
      end
   end

   // Status tracks regardless of enables; masking touches only the pulses
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_reg <= usie_pkg::STATUS_RST;
      end
      else if (CE)
      begin
         status_reg <= status_next;
      end
   end

   // Pulses last one enabled cycle; with CE low they hold, like the enable and status registers
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dev_irq_reg <= 1'b0;
         ctl_irq_reg <= 1'b0;
      end
      else if (CE)
      begin
         dev_irq_reg <= dev_irq_next;
         ctl_irq_reg <= ctl_irq_next;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   // Straight from flops, so nothing glitches between edges
   assign DEVICE_STATE_IRQ  = dev_irq_reg;
   assign CONTROL_STAGE_IRQ = ctl_irq_reg;
   assign STATUS_OUT        = status_reg;  // Reported even while masked
   assign ENABLE_OUT        = enable_reg;

endmodule : usie_irq_enables

/* File: sim/usie_irq_monitor.sv */
`timescale 1ns/1ps
module usie_irq_monitor
(
   // Block ports, watched only
   input wire logic                   MCLK, RST_B, CE,
   input wire logic [7:0]             NOTIFY_ENABLE, ENABLE_OUT,
   input wire usie_pkg::usie_status_s CORE_STATUS, STATUS_OUT,
   input wire logic                   DEVICE_STATE_IRQ, CONTROL_STAGE_IRQ
);
   logic [1:0] live_reg;
   wire        ok = live_reg[1] && CE;
   // Mirror of the reset sync, so load edges are known
   always_ff @(posedge MCLK or negedge RST_B)
      if (!RST_B) live_reg <= 2'h0;
      else live_reg <= {live_reg[0], 1'b1};
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   // Entry to s pulses only if bit b was set before
   property dev_p(logic [2:0] s, int b);
      $past(ok) && $past(CORE_STATUS.dev_state) == s && $past(STATUS_OUT.dev_state) != s
         |-> DEVICE_STATE_IRQ == $past(ENABLE_OUT[b]);
   endproperty
   property stg_p(logic [2:0] s, int b);
      $past(ok) && $past(CORE_STATUS.ctrl_stage) == s && $past(STATUS_OUT.ctrl_stage) != s
         |-> CONTROL_STAGE_IRQ == $past(ENABLE_OUT[b]);
   endproperty
   addr_irq_a: assert property (dev_p(3'h2, 6)) else $error("addr");
   cfg_irq_a: assert property (dev_p(3'h3, 5)) else $error("cfg");
   suspend_notify_en_irq_a: assert property (dev_p(3'h4, 4)) else $error("suspend_notify_en");
   dflt_irq_a: assert property (dev_p(3'h1, 7)) else $error("dflt");
   cwr_irq_a: assert property (stg_p(3'h5, 3)) else $error("cwr");
   crd_irq_a: assert property (stg_p(3'h3, 2)) else $error("crd");
   en_copy_a: assert property ($past(ok) |-> ENABLE_OUT == $past(NOTIFY_ENABLE)) else $error("en");
   state_track_a: assert property ($past(ok) |-> STATUS_OUT == $past(CORE_STATUS)) else $error("st");
   cover property (DEVICE_STATE_IRQ);
   cover property (CONTROL_STAGE_IRQ);
   cover property (DEVICE_STATE_IRQ && CONTROL_STAGE_IRQ);
endmodule : usie_irq_monitor
bind usie_irq_enables usie_irq_monitor mon
(
   .MCLK              (MCLK),
   .RST_B             (RST_B),
   .CE                (CE),
   .NOTIFY_ENABLE     (NOTIFY_ENABLE),
   .ENABLE_OUT        (ENABLE_OUT),
   .CORE_STATUS       (CORE_STATUS),
   .STATUS_OUT        (STATUS_OUT),
   .DEVICE_STATE_IRQ  (DEVICE_STATE_IRQ),
   .CONTROL_STAGE_IRQ (CONTROL_STAGE_IRQ)
);

/* File: sim/usie_irq_enables_bench.sv */
`timescale 1ns/1ps
module usie_irq_enables_bench;
   logic                   MCLK = 1'b0, RST_B = 1'b0, CE = 1'b1, DEVICE_STATE_IRQ, CONTROL_STAGE_IRQ;
   logic [7:0]             NOTIFY_ENABLE = 8'h00, ENABLE_OUT, m_en = 8'h00;
   usie_pkg::usie_status_s CORE_STATUS = 6'h00, STATUS_OUT;
   logic [5:0]             m_st = 6'h00;
   logic [15:0]            exp_v = 16'h0000;
   int                     err_total = 0, check_count = 0;
   wire [15:0]             seen_v = {DEVICE_STATE_IRQ, CONTROL_STAGE_IRQ, STATUS_OUT, ENABLE_OUT};
   always #2 MCLK = ~MCLK;
   usie_irq_enables uut
   (
      .MCLK              (MCLK),
      .RST_B             (RST_B),
      .CE                (CE),
      .NOTIFY_ENABLE     (NOTIFY_ENABLE),
      .CORE_STATUS       (CORE_STATUS),
      .DEVICE_STATE_IRQ  (DEVICE_STATE_IRQ),
      .CONTROL_STAGE_IRQ (CONTROL_STAGE_IRQ),
      .STATUS_OUT        (STATUS_OUT),
      .ENABLE_OUT        (ENABLE_OUT)
   );
   // One compare, counted
   task automatic check(input logic [15:0] seen, want);
      check_count++;
      if (seen !== want)
      begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, seen, want);
      end
   endtask : check
   // Expected pulses: entry into a state whose enable was set the cycle before
   function automatic logic exp_dev(input logic [2:0] now_s, old_s, input logic [7:0] en);
      return now_s != old_s && now_s != 3'h0 && en[8 - now_s];
   endfunction : exp_dev
   function automatic logic exp_ctl(input logic [2:0] now_g, old_g, input logic [7:0] en);
      return now_g != old_g && (now_g == 3'h5 && en[3] || now_g == 3'h3 && en[2]);
   endfunction : exp_ctl
   // Drive, check last cycle, then predict; CE low holds all
   task automatic cyc(input logic [7:0] en, input logic [5:0] st, input logic ce);
      @(posedge MCLK);
      NOTIFY_ENABLE <= en;
      CORE_STATUS <= st;
      CE <= ce;
      @(negedge MCLK);
      check(seen_v, exp_v);
      if (!ce) return;
      exp_v = {exp_dev(st[5:3], m_st[5:3], m_en), exp_ctl(st[2:0], m_st[2:0], m_en), st, en};
      m_st = st;
      m_en = en;
   endtask : cyc
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   // Two passes from reset: walk every state per single enable, random traffic, mid-run reset
   initial
   begin
      void'($urandom(18619));
      repeat (20) @(posedge MCLK);
      for (int p = 0; p < 2; p++)
      begin
         RST_B <= 1'b1;
         repeat (3) @(posedge MCLK);
         exp_v = 16'h0000;
         m_st = 6'h00;
         m_en = 8'h00;
         for (int t = 0; t < 10; t++)
         begin
            for (int k = 1; k < 15; k++)
               cyc(t < 8 ? 8'h01 << t : (t == 8 ? 8'hFC : 8'h00), {3'(k % 5), 3'(k % 7)}, 1'b1);
            $display("walk %0d done", t);
         end
         for (int i = 0; i < 3000; i++)
            cyc(8'($urandom), {3'($urandom_range(4)), 3'($urandom_range(6))}, $urandom_range(3) != 0);
         // Frozen cycle so the last prediction is still compared
         cyc(8'h00, 6'h00, 1'b0);
         $display("random done");
         // Reset clears every output at once, before any edge
         @(posedge MCLK);
         RST_B <= 1'b0;
         NOTIFY_ENABLE <= 8'h00;
         CORE_STATUS <= 6'h00;
         CE <= 1'b1;
         @(negedge MCLK);
         exp_v = {2'h0, usie_pkg::STATUS_RST, usie_pkg::ENABLE_RST};
         check(seen_v, exp_v);
         repeat (20) @(posedge MCLK);
         $display("reset pass %0d done", p);
      end
      give_verdict();
   end
endmodule : usie_irq_enables_bench
